// ==== acp_chk.sv ====
// Concurrent checks on the configuration port pins and register outputs.
`timescale 1ns/10ps
`default_nettype none
module acp_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Pins and strap.
	input wire acp_pkg::acp_pin_in_s pin_in,
	input wire acp_pkg::acp_pin_out_s pin_out,
	input wire logic no_select_mode,
	// Calibration and register state.
	input wire logic cal_load,
	input wire acp_pkg::acp_trim_s [1:0] cal_trim,
	input wire acp_pkg::acp_trim_s [1:0] core_trim,
	input wire logic [1:0] core_pick,
	input wire logic four_wire_enable,
	input wire logic lsb_first
);
	import acp_pkg::*;
	// ==========================================================
	// One clock domain, so clocking and disable are set once.
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// High while the port is plainly not selected.
	logic idle;
	assign idle = pin_in.select_low && !no_select_mode;
	a_out_follow_mode: assert property (
		pin_out.serial_out_oe == four_wire_enable) else $error("output enable off mode bit");
	a_no_dual_drive: assert property (
		pin_out.sdio_oe |-> !four_wire_enable) else $error("two-way line driven in four-wire");
	a_line_free_idle: assert property (
		idle [*4] |-> !pin_out.sdio_oe) else $error("line driven while not selected");
	a_oe_drop_desel: assert property (
		$rose(pin_in.select_low) && !no_select_mode |-> ##[1:4] !pin_out.sdio_oe)
		else $error("line held after select rose");
	a_reset_defaults: assert property (
		$fell(srst) |-> core_pick == 2'b00 && !four_wire_enable && !lsb_first
		&& core_trim == {TRIM_DEF, TRIM_DEF}) else $error("state not at defaults");
	a_cal_loads_trim: assert property (
		cal_load |=> core_trim == $past(cal_trim)) else $error("calibration not loaded");
	a_regs_quiet_idle: assert property (
		(idle && !cal_load) [*6] |-> $stable(core_trim) && $stable(core_pick)
		&& $stable(lsb_first)) else $error("register changed while idle");
	a_out_holds_high: assert property (
		pin_in.sclk [*4] |-> $stable(pin_out.sdio_out)) else $error("read bit moved on high clock");
endmodule : acp_chk
bind acp_serial_port acp_chk acp_chk_i (.clk(clk), .srst(srst), .pin_in(pin_in),
	.pin_out(pin_out), .no_select_mode(no_select_mode), .cal_load(cal_load),
	.cal_trim(cal_trim), .core_trim(core_trim), .core_pick(core_pick),
	.four_wire_enable(four_wire_enable), .lsb_first(lsb_first));
`default_nettype wire

// ==== acp_master.sv ====
// Serial bus master model driving the configuration port pins.
`timescale 1ns/10ps
`default_nettype none
module acp_master #(
	// Clocks per half period of the serial clock.
	parameter int HALF = 5
) (
	// Clock.
	input wire logic clk,
	// Device side of the pins.
	input wire acp_pkg::acp_pin_out_s dev,
	output var acp_pkg::acp_pin_in_s pins
);
	import acp_pkg::*;
	// ==========================================================
	// Pin state; a line nobody drives shows the inverse bit, never a held value.
	logic sel_n = 1'b1;
	logic sck = 1'b0;
	logic drv = 1'b0;
	logic b = 1'b0;
	// Mode the bench believes is set in the device.
	logic four = 1'b0;
	logic lsb = 1'b0;
	assign pins.select_low = sel_n;
	assign pins.sclk = sck;
	assign pins.sdio_in = dev.sdio_oe ? dev.sdio_out : ((drv && !four) ? b : !b);
	assign pins.serial_in_line = (drv && four) ? b : !b;
	// Shift n bits, sampling the answer just before each rise.
	// slow serial clock.
	task automatic shift(input int n, input logic [15:0] w, input logic d,
		output logic [15:0] r);
		int k;
		r = '0;
		for (int i = 0; i < n; i++) begin
			k = lsb ? i : n - 1 - i;
			@(posedge clk);
			drv <= d;
			b <= w[k];
			repeat (HALF) @(posedge clk);
			r[k] = four ? dev.serial_out_line : pins.sdio_in;
			sck <= 1'b1;
			repeat (HALF) @(posedge clk);
			sck <= 1'b0;
		end
	endtask : shift
	task automatic sel(input logic v);
		@(posedge clk);
		sel_n <= v;
		drv <= 1'b0;
		repeat (2 * HALF) @(posedge clk);
	endtask : sel
endmodule : acp_master
`default_nettype wire

// ==== acp_pkg.sv ====
// Constants and types shared by the ADC serial configuration port.
package acp_pkg;

	// ==========================================================
	// Register offsets in the 13-bit serial address space.
	localparam logic [12:0] OFS_PORT_SETUP = 13'h0000;
	localparam logic [12:0] OFS_BURST_STOP = 13'h0002;
	localparam logic [12:0] OFS_DIE_ID = 13'h0008;
	localparam logic [12:0] OFS_DIE_REV = 13'h0009;
	localparam logic [12:0] OFS_CORE_SEL = 13'h0010;
	localparam logic [12:0] OFS_OFFSET_BIG = 13'h0020;
	localparam logic [12:0] OFS_OFFSET_SMALL = 13'h0021;
	localparam logic [12:0] OFS_GAIN_BIG = 13'h0022;
	localparam logic [12:0] OFS_GAIN_MID = 13'h0023;
	localparam logic [12:0] OFS_GAIN_SMALL = 13'h0024;
	localparam logic [12:0] ADDR_STEP = 13'h0001;

	// ==========================================================
	// Port setup register fields.
	localparam int BIT_FOUR_WIRE = 7;
	localparam int BIT_LSB_FIRST = 6;
	localparam int BIT_SOFT_RST = 5;

	// ==========================================================
	// Reset values and fixed answers.
	localparam logic [7:0] PORT_SETUP_DEF = 8'h18;
	localparam logic [7:0] BURST_STOP_DEF = 8'h00;
	localparam logic [7:0] CORE_SEL_DEF = 8'h00;
	localparam logic [7:0] TRIM_NEUTRAL = 8'h80;
	localparam logic [3:0] GAIN_BIG_DEF = 4'h0;
	localparam logic [7:0] ERR_BYTE = 8'hAD;
	localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
	localparam logic [7:0] CORE_ZERO_PICK = 8'h01;
	localparam logic [7:0] CORE_ONE_PICK = 8'h02;
	localparam int NCORES = 2;

	// ==========================================================
	// Transfer counters.
	localparam logic [1:0] CNT_FOUR_PLUS = 2'h3;
	localparam logic [1:0] BYTES_STEP = 2'h1;
	localparam logic [1:0] BYTES_NONE = 2'h0;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] INSTR_LAST = 4'hF;
	localparam logic [2:0] BYTE_EDGE = 3'h0;

	// ==========================================================
	// Pin synchroniser layout: select, clock, line, input, strap.
	localparam int NPINS = 5;
	localparam int PIN_SEL = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_SDIO = 2;
	localparam int PIN_SDI = 3;
	localparam int PIN_NOSEL = 4;
	localparam logic [4:0] PIN_RST_VAL = 5'h01;

	// ==========================================================
	// Types.
	typedef enum logic {PH_INSTR = 1'b0, PH_DATA = 1'b1} acp_phase_e;
	typedef struct packed {
		logic select_low;
		logic sclk;
		logic sdio_in;
		logic serial_in_line;
	} acp_pin_in_s;
	typedef struct packed {
		logic sdio_out;
		logic sdio_oe;
		logic serial_out_line;
		logic serial_out_oe;
	} acp_pin_out_s;
	typedef struct packed {
		logic [7:0] offset_big;
		logic [7:0] offset_small;
		logic [3:0] gain_big;
		logic [7:0] gain_mid;
		logic [7:0] gain_small;
	} acp_trim_s;
	localparam acp_trim_s TRIM_DEF = '{TRIM_NEUTRAL, TRIM_NEUTRAL, GAIN_BIG_DEF,
		TRIM_NEUTRAL, TRIM_NEUTRAL};

endpackage : acp_pkg

// ==== acp_serial_port.sv ====
// Serial configuration slave with port setup, identity, core select and trim registers.
`timescale 1ns/10ps
`default_nettype none
module acp_serial_port #(
	// Die identifier, arbitrary value.
	parameter logic [7:0] DIE_ID = 8'h5A,
	// Die revision, arbitrary value.
	parameter logic [7:0] DIE_REV = 8'h01
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Serial pins.
	input wire acp_pkg::acp_pin_in_s pin_in,
	output var acp_pkg::acp_pin_out_s pin_out,
	// Strap: high when no select pin is fitted.
	input wire logic no_select_mode,
	// Calibration results from the cores.
	input wire logic cal_load,
	input wire acp_pkg::acp_trim_s [1:0] cal_trim,
	// Trim and mode state toward the cores.
	output var acp_pkg::acp_trim_s [1:0] core_trim,
	output var logic [1:0] core_pick,
	output var logic four_wire_enable,
	output var logic lsb_first
);
	import acp_pkg::*;

	// ==========================================================
	// Helper functions.

	// Mirrors a 16-bit word end to end.
	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction : rev16

	// Mirrors a byte end to end.
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction : rev8

	// True for the per-core trim addresses.
	function automatic logic is_indexed(input logic [12:0] a);
		return (a >= OFS_OFFSET_BIG) && (a <= OFS_GAIN_SMALL);
	endfunction : is_indexed

	// ==========================================================
	// Declarations.
	logic [NPINS-1:0] pin_vec; // Raw pin levels in synchroniser order.
	logic [NPINS-1:0] meta_reg; // First stage, read only by the second.
	logic [NPINS-1:0] stab_reg; // Second stage, safe to use.
	logic sclk_prev_reg; // Clock level one cycle ago.
	logic sel_prev_reg; // Select-high level one cycle ago.
	logic selected; // Port addressed, by pin or by strap.
	logic sclk_rise; // Serial clock rising edge seen.
	logic sclk_fall; // Serial clock falling edge seen.
	logic sel_rise; // Select released on a fitted pin.
	logic in_bit; // Serial data bit from the active input line.
	logic [15:0] sh_next; // Input shifter with the new bit added.
	acp_phase_e phase_reg; // Instruction or data phase.
	logic [3:0] bit_cnt_reg; // Bits taken in the current word.
	logic [15:0] sh_reg; // Input shifter.
	logic rw_reg; // High for a read transfer.
	logic [1:0] cnt_code_reg; // Byte count code of this transfer.
	logic [12:0] addr_reg; // Address of the current data byte.
	logic [1:0] bytes_done_reg; // Data bytes finished, saturating.
	logic [7:0] rd_byte_reg; // Byte being shifted out.
	logic out_bit_reg; // Bit on the serial output.
	logic [15:0] instr_word; // Instruction in natural order.
	logic [7:0] byte_in; // Received data byte in natural order.
	logic [12:0] addr_step; // Address of the following byte.
	logic instr_done; // Last instruction bit taken.
	logic byte_done; // Last data bit taken.
	logic xfer_end; // Transfer finishes with this byte.
	logic [12:0] rd_addr; // Address whose value is loaded next.
	logic [7:0] rd_data; // Value read from rd_addr.
	logic wr_en; // Data byte to be written this cycle.
	logic soft_rst; // Software reset request.
	logic [7:0] port_setup_reg; // Port setup register.
	logic [7:0] burst_stop_reg; // Burst stop address register.
	logic [7:0] core_sel_reg; // Core select register.
	logic pick_ok; // Exactly one core selected.
	acp_trim_s trim_reg [NCORES]; // Per-core trim registers.
	acp_trim_s trim_sel; // Trims of the selected core.

	// ==========================================================
	// Pin synchronisers.

	assign pin_vec = {no_select_mode, pin_in.serial_in_line, pin_in.sdio_in,
		pin_in.sclk, pin_in.select_low};

	// Two flops per pin; select resets high so nothing starts early.
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= PIN_RST_VAL;
			stab_reg <= PIN_RST_VAL;
		end else begin
			meta_reg <= pin_vec;
			stab_reg <= meta_reg;
		end
	end

	// Edge history for the serial clock and the select pin.
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= stab_reg[PIN_SCLK];
			sel_prev_reg <= stab_reg[PIN_SEL];
		end
	end

	// With the strap set the port behaves as if always selected.
	assign selected = ~stab_reg[PIN_SEL] | stab_reg[PIN_NOSEL];
	assign sclk_rise = selected & stab_reg[PIN_SCLK] & ~sclk_prev_reg;
	assign sclk_fall = selected & ~stab_reg[PIN_SCLK] & sclk_prev_reg;
	assign sel_rise = ~stab_reg[PIN_NOSEL] & stab_reg[PIN_SEL] & ~sel_prev_reg;

	// ==========================================================
	// Receive path decoding.

	assign in_bit = four_wire_enable ? stab_reg[PIN_SDI] : stab_reg[PIN_SDIO];
	assign sh_next = {sh_reg[14:0], in_bit};
	assign instr_word = lsb_first ? rev16(sh_next) : sh_next;
	assign byte_in = lsb_first ? rev8(sh_next[7:0]) : sh_next[7:0];
	assign addr_step = lsb_first ? addr_reg - ADDR_STEP : addr_reg + ADDR_STEP;
	assign instr_done = sclk_rise && (phase_reg == PH_INSTR) && (bit_cnt_reg == INSTR_LAST);
	assign byte_done = sclk_rise && (phase_reg == PH_DATA) && (bit_cnt_reg == BYTE_LAST);
	assign wr_en = byte_done && !rw_reg;

	// The transfer ends when the counted bytes are done or, with the strap set, the stop address is hit.
	always_comb begin
		xfer_end = 1'b0;
		if (cnt_code_reg != CNT_FOUR_PLUS && bytes_done_reg == cnt_code_reg) begin
			xfer_end = 1'b1;
		end
		if (stab_reg[PIN_NOSEL] && addr_reg == 13'(burst_stop_reg)) begin
			xfer_end = 1'b1;
		end
	end

	// ==========================================================
	// Transfer state machine.

	// Shifts bits in on serial clock rises and walks through the bytes.
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_reg <= PH_INSTR;
			bit_cnt_reg <= BIT_FIRST;
			sh_reg <= '0;
			rw_reg <= 1'b0;
			cnt_code_reg <= BYTES_NONE;
			addr_reg <= '0;
			bytes_done_reg <= BYTES_NONE;
		end else if (sel_rise && bit_cnt_reg[2:0] != BYTE_EDGE) begin
			phase_reg <= PH_INSTR;
			bit_cnt_reg <= BIT_FIRST;
		end else if (sel_rise && phase_reg == PH_DATA && cnt_code_reg == CNT_FOUR_PLUS
			&& bytes_done_reg != BYTES_NONE) begin
			// late release ends a long burst.
			phase_reg <= PH_INSTR;
			bit_cnt_reg <= BIT_FIRST;
		end else if (sclk_rise) begin
			sh_reg <= sh_next;
			unique case (phase_reg)
				PH_INSTR: begin
					if (bit_cnt_reg == INSTR_LAST) begin
						rw_reg <= instr_word[15];
						cnt_code_reg <= instr_word[14:13];
						addr_reg <= instr_word[12:0];
						bytes_done_reg <= BYTES_NONE;
						phase_reg <= PH_DATA;
						bit_cnt_reg <= BIT_FIRST;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
					end
				end
				PH_DATA: begin
					if (bit_cnt_reg == BYTE_LAST) begin
						bit_cnt_reg <= BIT_FIRST;
						addr_reg <= addr_step;
						if (bytes_done_reg != CNT_FOUR_PLUS) begin
							bytes_done_reg <= bytes_done_reg + BYTES_STEP;
						end
						if (xfer_end) begin
							phase_reg <= PH_INSTR;
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Transmit path.

	// The next byte to send is fetched at the instruction end or the end of a byte.
	assign rd_addr = (phase_reg == PH_INSTR) ? instr_word[12:0] : addr_step;

	// Loads the read byte, then presents one bit per serial clock fall.
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_byte_reg <= '0;
			out_bit_reg <= 1'b0;
		end else begin
			if (instr_done || byte_done) begin
				rd_byte_reg <= rd_data;
			end
			// output bit order follows the setup.
			if (sclk_fall && phase_reg == PH_DATA && rw_reg) begin
				out_bit_reg <= lsb_first ? rd_byte_reg[bit_cnt_reg[2:0]]
					: rd_byte_reg[~bit_cnt_reg[2:0]];
			end
		end
	end

	// Pin drive; the far end resolves the line from the enables.
	always_comb begin
		pin_out.sdio_out = out_bit_reg;
		// release line except during read data in three-wire mode.
		pin_out.sdio_oe = ~four_wire_enable & selected & rw_reg & (phase_reg == PH_DATA);
		pin_out.serial_out_line = out_bit_reg;
		pin_out.serial_out_oe = four_wire_enable;
	end

	// ==========================================================
	// Register file.

	assign soft_rst = wr_en && (addr_reg == OFS_PORT_SETUP) && byte_in[BIT_SOFT_RST];
	// only one core at a time.
	assign pick_ok = (core_sel_reg == CORE_ZERO_PICK) || (core_sel_reg == CORE_ONE_PICK);
	assign trim_sel = (core_sel_reg == CORE_ONE_PICK) ? trim_reg[1] : trim_reg[0];

	// Global registers; the soft reset bit never stays set.
	// Power-down, divider and output-mode registers live elsewhere and are untouched.
	always_ff @(posedge clk) begin
		if (srst || soft_rst) begin
			port_setup_reg <= PORT_SETUP_DEF;
			burst_stop_reg <= BURST_STOP_DEF;
			core_sel_reg <= CORE_SEL_DEF;
		end else if (wr_en) begin
			unique case (addr_reg)
				OFS_PORT_SETUP: begin
					port_setup_reg <= byte_in;
				end
				OFS_BURST_STOP: begin
					burst_stop_reg <= byte_in;
				end
				OFS_CORE_SEL: begin
					core_sel_reg <= byte_in;
				end
				default: begin
					// Other addresses leave the global registers alone.
				end
			endcase
		end
	end

	// Per-core trims; a write goes only to the core picked at that moment.
	genvar gc;
	generate
		for (gc = 0; gc < NCORES; gc++) begin : g_core
			localparam logic [7:0] PICK = (gc == 0) ? CORE_ZERO_PICK : CORE_ONE_PICK;
			always_ff @(posedge clk) begin
				if (srst || soft_rst) begin
					// soft reset restores trims only here.
					trim_reg[gc] <= TRIM_DEF;
				end else if (cal_load) begin
					trim_reg[gc] <= cal_trim[gc];
				end else if (wr_en && is_indexed(addr_reg) && core_sel_reg == PICK) begin
					unique case (addr_reg)
						OFS_OFFSET_BIG: begin
							trim_reg[gc].offset_big <= byte_in;
						end
						OFS_OFFSET_SMALL: begin
							trim_reg[gc].offset_small <= byte_in;
						end
						OFS_GAIN_BIG: begin
							trim_reg[gc].gain_big <= byte_in[3:0];
						end
						OFS_GAIN_MID: begin
							trim_reg[gc].gain_mid <= byte_in;
						end
						OFS_GAIN_SMALL: begin
							trim_reg[gc].gain_small <= byte_in;
						end
						default: begin
							// Not reachable inside the indexed range.
						end
					endcase
				end
			end
			assign core_trim[gc] = trim_reg[gc];
		end
	endgenerate

	// Read decode; unmapped addresses answer zero.
	always_comb begin
		rd_data = UNMAPPED_BYTE;
		if (is_indexed(rd_addr) && !pick_ok) begin
			rd_data = ERR_BYTE;
		end else begin
			unique case (rd_addr)
				OFS_PORT_SETUP: rd_data = port_setup_reg;
				OFS_BURST_STOP: rd_data = burst_stop_reg;
				OFS_DIE_ID: rd_data = DIE_ID;
				OFS_DIE_REV: rd_data = DIE_REV;
				OFS_CORE_SEL: rd_data = core_sel_reg;
				OFS_OFFSET_BIG: rd_data = trim_sel.offset_big;
				OFS_OFFSET_SMALL: rd_data = trim_sel.offset_small;
				OFS_GAIN_BIG: rd_data = {4'h0, trim_sel.gain_big};
				OFS_GAIN_MID: rd_data = trim_sel.gain_mid;
				OFS_GAIN_SMALL: rd_data = trim_sel.gain_small;
				default: rd_data = UNMAPPED_BYTE;
			endcase
		end
	end

	// ==========================================================
	// Mode outputs.

	assign four_wire_enable = port_setup_reg[BIT_FOUR_WIRE];
	assign lsb_first = port_setup_reg[BIT_LSB_FIRST];
	assign core_pick = core_sel_reg[1:0];

endmodule : acp_serial_port
`default_nettype wire

// ==== tb_adc_serial_config_port.sv ====
// Self-checking bench for the serial configuration port.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_config_port;
	import acp_pkg::*;
	// Identity values, arbitrary.
	localparam logic [7:0] ID = 8'hC3;
	localparam logic [7:0] REV = 8'h07;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cal_load = 1'b0;
	logic no_select_mode = 1'b0;
	acp_trim_s [1:0] cal_trim = '0;
	acp_pin_in_s pin_in;
	acp_pin_out_s pin_out;
	acp_trim_s [1:0] core_trim;
	logic [1:0] core_pick;
	logic four_wire_enable;
	logic lsb_first;
	int errors = 0;
	int tests_run = 0;
	logic [15:0] junk;
	logic [7:0] v;
	always #50 clk = ~clk;
	acp_serial_port #(.DIE_ID(ID), .DIE_REV(REV)) acp_serial_port_i (.clk(clk), .srst(srst),
		.pin_in(pin_in), .pin_out(pin_out), .no_select_mode(no_select_mode),
		.cal_load(cal_load),
		.cal_trim(cal_trim), .core_trim(core_trim), .core_pick(core_pick),
		.four_wire_enable(four_wire_enable), .lsb_first(lsb_first));
	acp_master acp_master_i (.clk(clk), .dev(pin_out), .pins(pin_in));
	// ==========================================================
	// Compare and transfer helpers.
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic ins(input logic r, input logic [1:0] c, input logic [12:0] a);
		acp_master_i.sel(1'b0);
		acp_master_i.shift(16, {r, c, a}, 1'b1, junk);
	endtask : ins
	task automatic put(input logic [7:0] d);
		acp_master_i.shift(8, {8'h00, d}, 1'b1, junk);
	endtask : put
	task automatic get(output logic [7:0] d);
		acp_master_i.shift(8, 16'h0000, 1'b0, junk);
		d = junk[7:0];
	endtask : get
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		ins(1'b0, 2'h0, a);
		put(d);
		acp_master_i.sel(1'b1);
	endtask : wr
	task automatic rdc(input string nm, input logic [12:0] a, input logic [7:0] e);
		ins(1'b1, 2'h0, a);
		get(v);
		acp_master_i.sel(1'b1);
		chk(nm, v, e);
	endtask : rdc
	// ==========================================================
	// Reset values, identity and the guarded indexed read.
	task automatic t_reset;
		rdc("setup", OFS_PORT_SETUP, PORT_SETUP_DEF);
		rdc("stop", OFS_BURST_STOP, BURST_STOP_DEF);
		rdc("id", OFS_DIE_ID, ID);
		rdc("rev", OFS_DIE_REV, REV);
		rdc("csel", OFS_CORE_SEL, CORE_SEL_DEF);
		rdc("nocore", OFS_OFFSET_BIG, ERR_BYTE);
		wr(OFS_DIE_ID, 8'h00);
		rdc("ro_id", OFS_DIE_ID, ID);
		$display("test reset done");
	endtask : t_reset
	// Per-core writes with a pause after the second byte.
	task automatic t_index;
		wr(OFS_CORE_SEL, CORE_ONE_PICK);
		chk("pick", {6'h00, core_pick}, 8'h02);
		ins(1'b0, 2'h2, OFS_OFFSET_BIG);
		put(8'h11);
		put(8'h12);
		acp_master_i.sel(1'b1);
		acp_master_i.sel(1'b0);
		put(8'h1B);
		acp_master_i.sel(1'b1);
		chk("c1big", core_trim[1].offset_big, 8'h11);
		chk("c1gain", {4'h0, core_trim[1].gain_big}, 8'h0B);
		chk("c0big", core_trim[0].offset_big, TRIM_NEUTRAL);
		rdc("c1small", OFS_OFFSET_SMALL, 8'h12);
		wr(OFS_CORE_SEL, 8'h03);
		rdc("badpick", OFS_OFFSET_BIG, ERR_BYTE);
		wr(OFS_CORE_SEL, CORE_ZERO_PICK);
		rdc("c0mid", OFS_GAIN_MID, TRIM_NEUTRAL);
		$display("test index done");
	endtask : t_index
	// Every count code, then a read back in the same frame where allowed.
	task automatic t_counts;
		logic [7:0] e;
		for (int c = 0; c < 4; c++) begin
			ins(1'b0, c[1:0], OFS_OFFSET_SMALL);
			for (int i = 0; i <= c; i++)
				put(8'(8'h40 + 16 * c + i));
			if (c == 3)
				acp_master_i.sel(1'b1);
			ins(1'b1, c[1:0], OFS_OFFSET_SMALL);
			for (int i = 0; i <= c; i++) begin
				get(v);
				e = 8'(8'h40 + 16 * c + i);
				if (i == 1)
					e[7:4] = 4'h0;
				chk("count", v, e);
			end
			acp_master_i.sel(1'b1);
		end
		$display("test counts done");
	endtask : t_counts
	// Long burst: pause before data is fine, a later rise ends it.
	task automatic t_abort;
		ins(1'b0, 2'h3, OFS_GAIN_MID);
		acp_master_i.sel(1'b1);
		acp_master_i.sel(1'b0);
		put(8'h66);
		acp_master_i.sel(1'b1);
		wr(OFS_GAIN_SMALL, 8'h5C);
		rdc("mid", OFS_GAIN_MID, 8'h66);
		rdc("small", OFS_GAIN_SMALL, 8'h5C);
		$display("test abort done");
	endtask : t_abort
	// Bit order, address step, four-wire output and soft reset.
	task automatic t_modes;
		wr(OFS_PORT_SETUP, 8'h5A);
		acp_master_i.lsb = 1'b1;
		chk("lsb", {7'h00, lsb_first}, 8'h01);
		ins(1'b0, 2'h1, OFS_GAIN_SMALL);
		put(8'h71);
		put(8'h72);
		acp_master_i.sel(1'b1);
		rdc("dec", OFS_GAIN_MID, 8'h72);
		rdc("setup", OFS_PORT_SETUP, 8'h5A);
		wr(OFS_PORT_SETUP, 8'hDB);
		acp_master_i.four = 1'b1;
		chk("sdo_oe", {7'h00, pin_out.serial_out_oe}, 8'h01);
		rdc("fourrd", OFS_GAIN_SMALL, 8'h71);
		wr(OFS_PORT_SETUP, 8'hFF);
		acp_master_i.four = 1'b0;
		acp_master_i.lsb = 1'b0;
		chk("four_off", {7'h00, four_wire_enable}, 8'h00);
		chk("trim", core_trim[0].gain_small, TRIM_NEUTRAL);
		rdc("setup2", OFS_PORT_SETUP, PORT_SETUP_DEF);
		rdc("csel2", OFS_CORE_SEL, CORE_SEL_DEF);
		$display("test modes done");
	endtask : t_modes
	// Calibration load, then a read-modify-write of one trim.
	task automatic t_cal;
		@(posedge clk);
		cal_trim <= {TRIM_DEF, {8'h7E, 8'h81, 4'h3, 8'h90, 8'h8F}};
		cal_load <= 1'b1;
		@(posedge clk);
		cal_load <= 1'b0;
		repeat (2) @(posedge clk);
		chk("cal", core_trim[0].offset_big, 8'h7E);
		wr(OFS_CORE_SEL, CORE_ZERO_PICK);
		ins(1'b1, 2'h0, OFS_OFFSET_SMALL);
		get(v);
		acp_master_i.sel(1'b1);
		wr(OFS_OFFSET_SMALL, v + 8'h01);
		rdc("rmw", OFS_OFFSET_SMALL, 8'h82);
		$display("test cal done");
	endtask : t_cal
	// Strap mode: with no select pin the stop address ends a long burst.
	task automatic t_strap;
		wr(OFS_BURST_STOP, 8'h22);
		rdc("stop2", OFS_BURST_STOP, 8'h22);
		@(posedge clk);
		no_select_mode <= 1'b1;
		repeat (4) @(posedge clk);
		ins(1'b0, 2'h3, OFS_OFFSET_BIG);
		put(8'h31);
		put(8'h32);
		put(8'h0C);
		// A burst that runs on would swallow the next instruction as data.
		rdc("stop_end", OFS_GAIN_BIG, 8'h0C);
		rdc("stop_first", OFS_OFFSET_BIG, 8'h31);
		chk("stop_mid", core_trim[0].gain_mid, 8'h90);
		@(posedge clk);
		no_select_mode <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test strap done");
	endtask : t_strap
	// ==========================================================
	// Verdict and end of run.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_index();
		t_counts();
		t_abort();
		t_modes();
		t_cal();
		t_strap();
		tally_and_finish();
	end
	// Watchdog, well past the expected run of about one and a half milliseconds.
	initial begin
		#6000000;
		errors++;
		tally_and_finish();
	end
endmodule : tb_adc_serial_config_port
`default_nettype wire
